// ---- shared/esd_pkg.sv ----
/*
 * Constants, register layouts and carrier types of the engine shutdown
 * and throttle command block.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package esd_pkg;
	// Timing
	localparam int CLK_HZ       = 100_000_000;
	localparam int TICK_MS      = 1;
	localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
	localparam int SEL_HOLD_MS  = 1000;
	localparam int THR_HOLD_MS  = 2000;
	localparam int RAMP_RATE    = 50;
	localparam int RAMP_STEP_MS = 1000 / RAMP_RATE;
	localparam int TSC1_MS      = 10;
	localparam logic [15:0] STEP_RPM = 16'h000A;
	localparam logic [15:0] FINE_RPM = 16'h0001;

	// Register offsets
	localparam logic [7:0] OFS_CFG    = 8'h00;
	localparam logic [7:0] OFS_LIM    = 8'h04;
	localparam logic [7:0] OFS_ALM    = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0C;
	localparam logic [7:0] OFS_STS    = 8'h10;
	localparam logic [7:0] OFS_FAULT  = 8'h14;
	localparam logic [7:0] OFS_OVRCNT = 8'h18;
	localparam logic [7:0] OFS_SPEED  = 8'h1C;
	localparam int CMD_OVR_BIT = 0;

	// Reset values
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] LIM_RST = 32'h0A28_0320;
	localparam logic [31:0] ALM_RST = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		THR_RAMP = 2'b00,
		THR_TWO  = 2'b01,
		THR_OFF  = 2'b10
	} thr_mode_t;

	typedef enum logic {
		SRC_CAN    = 1'b0,
		SRC_ANALOG = 1'b1
	} thr_src_t;

	typedef struct packed {
		logic [28:0] rsvd;
		thr_src_t    src;
		thr_mode_t   mode;
	} cfg_t;

	typedef struct packed {
		logic [15:0] max;
		logic [15:0] min;
	} lim_t;

	typedef struct packed {
		logic [4:0]  rsvd;
		logic        en;
		logic        any;
		logic [4:0]  fmi;
		logic [19:0] spn;
	} alm_t;

	typedef struct packed {
		logic        valid;
		logic        active;
		logic [4:0]  fmi;
		logic [19:0] spn;
	} fault_t;

	typedef struct packed {
		logic [21:0] rsvd;
		thr_src_t    src;
		thr_mode_t   mode;
		logic        prompt_hold;
		logic        cycled;
		logic        override;
		logic        inhibit;
		logic        stale;
		logic        fault;
		logic        pending;
	} sts_t;
endpackage
`default_nettype wire

// ---- hw/press_timer.sv ----
/*
 * Pin synchroniser with press, release and long-hold detection.
 * Assumes a one-cycle tick enable that counts the hold time.
 */
`timescale 1ns/1ps
`default_nettype none
module press_timer #(
	parameter int HOLD = 1000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic tick,
	// Pin
	input  wire logic pin,
	// Decoded
	output logic      level,
	output logic      rise,
	output logic      fall,
	output logic      held_rise,
	output logic      held
);
	localparam int W = $clog2(HOLD + 1);

	logic         s1;
	logic         s2;
	logic [W-1:0] cnt;

	// Two-stage synchroniser, then one stage for edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			level <= s2;
		end
	end

	// Hold time in ticks, saturating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= '0;
		else if (!level)
			cnt <= '0;
		else if (tick && cnt != W'(HOLD))
			cnt <= cnt + W'(1);
	end

	assign rise      = s2 & ~level;
	assign fall      = ~s2 & level;
	assign held      = (cnt == W'(HOLD));
	assign held_rise = level & s2 & tick & (cnt == W'(HOLD - 1));
endmodule // press_timer
`default_nettype wire

// ---- hw/engine_shutdown_throttle_ctrl.sv ----
/*
 * Engine command logic: shutdown alarm latch, start inhibit and override,
 * throttle switch interpretation and speed command, AXI4-Lite registers.
 * Assumes fault, regeneration and analog inputs come from logic on MCLK;
 * buttons, switches and ignition are pins and are synchronised here.
 */
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module engine_shutdown_throttle_ctrl #(
	parameter int TICK_CYCLES = esd_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 RESET_N,
	// AXI4-Lite slave
	input  wire logic [7:0]           S_AXI_AWADDR,
	input  wire logic                 S_AXI_AWVALID,
	output logic                      S_AXI_AWREADY,
	input  wire logic [31:0]          S_AXI_WDATA,
	input  wire logic [3:0]           S_AXI_WSTRB,
	input  wire logic                 S_AXI_WVALID,
	output logic                      S_AXI_WREADY,
	output logic [1:0]                S_AXI_BRESP,
	output logic                      S_AXI_BVALID,
	input  wire logic                 S_AXI_BREADY,
	input  wire logic [7:0]           S_AXI_ARADDR,
	input  wire logic                 S_AXI_ARVALID,
	output logic                      S_AXI_ARREADY,
	output logic [31:0]               S_AXI_RDATA,
	output logic [1:0]                S_AXI_RRESP,
	output logic                      S_AXI_RVALID,
	input  wire logic                 S_AXI_RREADY,
	// Operator pins
	input  wire logic                 IGNITION,
	input  wire logic                 BTN_UP,
	input  wire logic                 BTN_DOWN,
	input  wire logic                 BTN_SELECT,
	input  wire logic                 THR_RAISE,
	input  wire logic                 THR_LOWER,
	// Engine side inputs
	input  wire esd_pkg::fault_t      FAULT,
	input  wire logic                 REGEN_INHIBIT_RX,
	input  wire logic                 REGEN_HOT_RX,
	input  wire logic [15:0]          ANALOG_RPM,
	// Prompt screens
	input  wire logic                 PROMPT_ON,
	input  wire logic                 PROMPT_NEED_ACK,
	output logic                      PROMPT_ALLOW,
	output logic                      PROMPT_DELAY,
	output logic                      PROMPT_ACK,
	output logic                      PROMPT_HOLD,
	// Alarm outputs
	output logic                      ENGINE_STOP,
	output logic                      START_INHIBIT,
	output logic                      POPUP,
	output logic [19:0]               POPUP_SPN,
	output logic [4:0]                POPUP_FMI,
	output logic                      RED_STATE,
	output logic                      AUDIBLE,
	output logic                      CHECK_ENGINE,
	output logic                      STOP_ICON,
	output logic                      REGEN_INH_ICON,
	output logic                      REGEN_ACT_ICON,
	// Speed command
	output logic                      TSC1_SEND,
	output logic [15:0]               TSC1_RPM
);
	localparam int N_PIN = 6;
	localparam int P_IGN = 0;
	localparam int P_UP  = 1;
	localparam int P_DN  = 2;
	localparam int P_SEL = 3;
	localparam int P_RAI = 4;
	localparam int P_LOW = 5;
	localparam int TW    = $clog2(TICK_CYCLES);

	logic [TW-1:0]      tcnt;
	logic               tick;
	logic [N_PIN-1:0]   pins;
	logic [N_PIN-1:0]   lvl;
	logic [N_PIN-1:0]   rise;
	logic [N_PIN-1:0]   fall;
	logic [N_PIN-1:0]   hrise;
	logic [N_PIN-1:0]   held;
	logic               ign_on;
	logic               sel_short;
	esd_pkg::cfg_t      cfg_reg, saved_cfg, act_cfg, cur_cfg;
	esd_pkg::lim_t      lim_reg, saved_lim, act_lim, cur_lim;
	esd_pkg::alm_t      alm_reg;
	logic               match, new_act, fault_on;
	logic               pending, stale, inhibit, cycled, override;
	logic               ovr_req, ovr_acc, ack;
	logic [31:0]        ovr_cnt;
	logic               thr_cmd, step_tick;
	logic [4:0]         rcnt;
	logic [3:0]         pcnt;
	logic [15:0]        speed, next_speed;
	logic               need_q;
	logic               aw_hold, w_hold, wr_go;
	logic [7:0]         waddr;
	logic [31:0]        wdata;
	logic [3:0]         wstrb;
	logic [31:0]        rd_data;
	logic [1:0]         rd_resp;
	esd_pkg::sts_t      sts;

	function automatic logic [15:0] clampv(input logic [15:0] s,
			input logic up, input logic [15:0] d, input esd_pkg::lim_t l);
		logic [16:0] v;
		v = up ? {1'b0, s} + {1'b0, d} : {1'b0, s} - {1'b0, d};
		if (!up && d > s)
			return l.min;
		if (v > {1'b0, l.max})
			return l.max;
		if (v < {1'b0, l.min})
			return l.min;
		return v[15:0];
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				o[8*i +: 8] = d[8*i +: 8];
		end
		return o;
	endfunction

	// 1 ms tick divider
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N)
			tcnt <= '0;
		else if (tick)
			tcnt <= '0;
		else
			tcnt <= tcnt + TW'(1);
	end
	assign tick = (tcnt == TW'(TICK_CYCLES - 1));

	// Pin conditioning
	assign pins = {THR_LOWER, THR_RAISE, BTN_SELECT, BTN_DOWN, BTN_UP,
		IGNITION};
	for (genvar i = 0; i < N_PIN; i++) begin : g_pin
		press_timer #(
			.HOLD(i == P_SEL ? esd_pkg::SEL_HOLD_MS / esd_pkg::TICK_MS
				: esd_pkg::THR_HOLD_MS / esd_pkg::TICK_MS)
		) u_pin (
			.clk      (MCLK),
			.rst_n    (RESET_N),
			.tick     (tick),
			.pin      (pins[i]),
			.level    (lvl[i]),
			.rise     (rise[i]),
			.fall     (fall[i]),
			.held_rise(hrise[i]),
			.held     (held[i])
		);
	end
	assign ign_on    = rise[P_IGN];
	assign sel_short = fall[P_SEL] & ~held[P_SEL];
	assign ack       = sel_short & POPUP;

	// Fault matching
	assign match = FAULT.valid && alm_reg.en && FAULT.spn == alm_reg.spn
		&& (alm_reg.any || FAULT.fmi == alm_reg.fmi);
	assign new_act = match && FAULT.active && !fault_on;

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fault_on  <= 1'b0;
			POPUP_SPN <= '0;
			POPUP_FMI <= '0;
		end else begin
			if (match)
				fault_on <= FAULT.active;
			if (new_act) begin
				POPUP_SPN <= FAULT.spn;
				POPUP_FMI <= FAULT.fmi;
			end
		end
	end

	// Unacknowledged alarm and stale recall
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pending <= 1'b0;
			stale   <= 1'b0;
		end else begin
			if (new_act || (ign_on && fault_on))
				pending <= 1'b1;
			else if (ack)
				pending <= 1'b0;
			if (ign_on && !ack)
				stale <= pending && !fault_on;
			else if (ack || new_act)
				stale <= 1'b0;
		end
	end

	// Start inhibit, key cycle and override
	assign ovr_req = wr_go && waddr == esd_pkg::OFS_CMD && wstrb[0]
		&& wdata[esd_pkg::CMD_OVR_BIT];
	assign ovr_acc = ovr_req && inhibit && cycled && lvl[P_IGN];

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			inhibit  <= 1'b0;
			cycled   <= 1'b0;
			override <= 1'b0;
		end else begin
			if (new_act)
				inhibit <= 1'b1;
			else if (ign_on)
				inhibit <= fault_on || (pending && !ack);
			if (new_act)
				cycled <= 1'b0;
			else if (ign_on)
				cycled <= 1'b1;
			if (ign_on)
				override <= 1'b0;
			else if (ovr_acc)
				override <= 1'b1;
		end
	end

	// Override history, kept across key cycles
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N)
			ovr_cnt <= '0;
		else if (ovr_acc)
			ovr_cnt <= ovr_cnt + 32'h0000_0001;
	end

	assign START_INHIBIT = inhibit & ~override;
	assign ENGINE_STOP   = START_INHIBIT;
	assign POPUP         = pending & (fault_on | stale);
	assign AUDIBLE       = POPUP;
	assign RED_STATE     = POPUP | inhibit;
	assign CHECK_ENGINE  = inhibit;
	assign STOP_ICON     = inhibit;

	// Regeneration indicators
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REGEN_INH_ICON <= 1'b0;
			REGEN_ACT_ICON <= 1'b0;
		end else begin
			REGEN_INH_ICON <= REGEN_INHIBIT_RX;
			REGEN_ACT_ICON <= REGEN_HOT_RX;
		end
	end

	// Prompt keys
	assign PROMPT_ALLOW = PROMPT_ON & rise[P_DN];
	assign PROMPT_DELAY = PROMPT_ON & rise[P_UP];
	assign PROMPT_ACK   = PROMPT_ON & sel_short & ~POPUP;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			need_q      <= 1'b0;
			PROMPT_HOLD <= 1'b0;
		end else begin
			need_q <= PROMPT_ON & PROMPT_NEED_ACK;
			if (PROMPT_ON && PROMPT_NEED_ACK && !need_q)
				PROMPT_HOLD <= 1'b1;
			else if (PROMPT_ACK)
				PROMPT_HOLD <= 1'b0;
		end
	end

	// Settings: saved on long select, applied on throttle command
	assign thr_cmd = rise[P_RAI] | rise[P_LOW];
	assign cur_cfg = thr_cmd ? saved_cfg : act_cfg;
	assign cur_lim = thr_cmd ? saved_lim : act_lim;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			saved_cfg <= esd_pkg::CFG_RST;
			saved_lim <= esd_pkg::LIM_RST;
			act_cfg   <= esd_pkg::CFG_RST;
			act_lim   <= esd_pkg::LIM_RST;
		end else begin
			if (hrise[P_SEL]) begin
				saved_cfg <= cfg_reg;
				saved_lim <= lim_reg;
			end
			if (thr_cmd) begin
				act_cfg <= saved_cfg;
				act_lim <= saved_lim;
			end
		end
	end

	// Ramp slew and message period, counted in ticks
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rcnt <= '0;
			pcnt <= '0;
		end else begin
			if (!(held[P_RAI] ^ held[P_LOW]) || step_tick)
				rcnt <= '0;
			else if (tick)
				rcnt <= rcnt + 5'h01;
			if (tick)
				pcnt <= (pcnt == 4'(esd_pkg::TSC1_MS - 1)) ? 4'h0
					: pcnt + 4'h1;
		end
	end
	assign step_tick = tick && (held[P_RAI] ^ held[P_LOW])
		&& rcnt == 5'(esd_pkg::RAMP_STEP_MS - 1);

	// Requested speed, mode interpretation
	always_comb begin
		next_speed = clampv(speed, 1'b1, 16'h0000, act_lim);
		case (cur_cfg.mode)
			esd_pkg::THR_TWO: begin
				if (thr_cmd)
					next_speed = rise[P_RAI] ? cur_lim.max
						: cur_lim.min;
			end
			esd_pkg::THR_RAMP: begin
				if (thr_cmd)
					next_speed = clampv(speed, rise[P_RAI],
						esd_pkg::STEP_RPM, cur_lim);
				else if (step_tick)
					next_speed = clampv(speed, held[P_RAI],
						esd_pkg::FINE_RPM, cur_lim);
			end
			default: ;
		endcase
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N)
			speed <= esd_pkg::LIM_RST[15:0];
		else
			speed <= next_speed;
	end

	// Speed message, suppressed when disabled
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			TSC1_SEND <= 1'b0;
			TSC1_RPM  <= '0;
		end else begin
			TSC1_SEND <= tick && pcnt == 4'(esd_pkg::TSC1_MS - 1)
				&& (act_cfg.mode == esd_pkg::THR_RAMP
				|| act_cfg.mode == esd_pkg::THR_TWO);
			TSC1_RPM  <= act_cfg.src == esd_pkg::SRC_ANALOG
				? clampv(ANALOG_RPM, 1'b1, 16'h0000, act_lim)
				: speed;
		end
	end

	// AXI4-Lite write path
	assign S_AXI_AWREADY = ~aw_hold & ~S_AXI_BVALID;
	assign S_AXI_WREADY  = ~w_hold & ~S_AXI_BVALID;
	assign wr_go         = aw_hold & w_hold & ~S_AXI_BVALID;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			waddr        <= '0;
			wdata        <= '0;
			wstrb        <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= esd_pkg::RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold <= 1'b1;
				waddr   <= {S_AXI_AWADDR[7:2], 2'b00};
			end else if (wr_go)
				aw_hold <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold <= 1'b1;
				wdata  <= S_AXI_WDATA;
				wstrb  <= S_AXI_WSTRB;
			end else if (wr_go)
				w_hold <= 1'b0;
			if (wr_go) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (waddr == esd_pkg::OFS_CFG
					|| waddr == esd_pkg::OFS_LIM
					|| waddr == esd_pkg::OFS_ALM
					|| waddr == esd_pkg::OFS_CMD) ? esd_pkg::RESP_OKAY
					: esd_pkg::RESP_SLVERR;
			end else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Writable settings; reserved bits held at zero
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_reg <= esd_pkg::CFG_RST;
			lim_reg <= esd_pkg::LIM_RST;
			alm_reg <= esd_pkg::ALM_RST;
		end else if (wr_go) begin
			if (waddr == esd_pkg::OFS_CFG)
				cfg_reg <= wmerge(cfg_reg, wdata, wstrb) & 32'h0000_0007;
			if (waddr == esd_pkg::OFS_LIM)
				lim_reg <= wmerge(lim_reg, wdata, wstrb);
			if (waddr == esd_pkg::OFS_ALM)
				alm_reg <= wmerge(alm_reg, wdata, wstrb) & 32'h07FF_FFFF;
		end
	end

	// AXI4-Lite read path
	always_comb begin
		sts             = '0;
		sts.pending     = pending;
		sts.fault       = fault_on;
		sts.stale       = stale;
		sts.inhibit     = inhibit;
		sts.override    = override;
		sts.cycled      = cycled;
		sts.prompt_hold = PROMPT_HOLD;
		sts.mode        = act_cfg.mode;
		sts.src         = act_cfg.src;
		rd_resp         = esd_pkg::RESP_OKAY;
		case ({S_AXI_ARADDR[7:2], 2'b00})
			esd_pkg::OFS_CFG:    rd_data = cfg_reg;
			esd_pkg::OFS_LIM:    rd_data = lim_reg;
			esd_pkg::OFS_ALM:    rd_data = alm_reg;
			esd_pkg::OFS_CMD:    rd_data = 32'h0000_0000;
			esd_pkg::OFS_STS:    rd_data = sts;
			esd_pkg::OFS_FAULT:  rd_data = {7'h00, POPUP_FMI, POPUP_SPN};
			esd_pkg::OFS_OVRCNT: rd_data = ovr_cnt;
			esd_pkg::OFS_SPEED:  rd_data = {16'h0000, speed};
			default: begin
				rd_data = 32'h0000_0000;
				rd_resp = esd_pkg::RESP_SLVERR;
			end
		endcase
	end

	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= '0;
			S_AXI_RRESP  <= esd_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_data;
			S_AXI_RRESP  <= rd_resp;
		end else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end

	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	stop_on_alarm_a: assert property (new_act |=>
		ENGINE_STOP && POPUP && POPUP_SPN == $past(FAULT.spn))
		else $error("alarm did not stop engine");
	popup_alert_a: assert property (POPUP && !ack
		&& !ign_on && !match && (fault_on || stale)
		|=> AUDIBLE && RED_STATE)
		else $error("popup lost alert");
	ack_keeps_red_a: assert property (ack && !new_act
		&& !ign_on |=> !POPUP && RED_STATE
		&& STOP_ICON && CHECK_ENGINE)
		else $error("acknowledge state wrong");
	ack_no_start_a: assert property (ack && inhibit
		&& !override && !ign_on |=> START_INHIBIT)
		else $error("acknowledge lifted inhibit");
	stale_recall_a: assert property (ign_on && pending
		&& !ack && !fault_on && !match |=> POPUP && START_INHIBIT)
		else $error("stale alarm not recalled");
	override_cancel_a: assert property (ign_on |=> !override)
		else $error("override survived key cycle");
	override_count_a: assert property (ovr_acc
		|=> ovr_cnt == $past(ovr_cnt) + 32'h0000_0001)
		else $error("override not counted");
	ramp_step_a: assert property (thr_cmd && rise[P_RAI]
		&& !rise[P_LOW] && cur_cfg.mode == esd_pkg::THR_RAMP
		&& speed >= cur_lim.min
		&& {1'b0, speed} + 17'h0000A <= {1'b0, cur_lim.max}
		|=> speed == $past(speed) + esd_pkg::STEP_RPM)
		else $error("ramp step wrong");
	two_state_a: assert property (thr_cmd && rise[P_RAI]
		&& cur_cfg.mode == esd_pkg::THR_TWO
		|=> speed == $past(cur_lim.max))
		else $error("two-state max not set");
	tsc_disabled_a: assert property (TSC1_SEND
		|-> $past(act_cfg.mode) != esd_pkg::THR_OFF)
		else $error("speed message sent while disabled");
	short_select_a: assert property (sel_short
		|=> saved_cfg == $past(saved_cfg))
		else $error("short press committed");
endmodule // engine_shutdown_throttle_ctrl
`default_nettype wire

// ---- sim/ecu_model.sv ----
/* Engine ECU stand-in: fault reports, regeneration status, frame count.
   Assumes the bench calls its tasks and that it shares the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module ecu_model (
	// Clock and speed message
	input  wire logic       MCLK,
	input  wire logic       TSC1_SEND,
	// Engine status
	output esd_pkg::fault_t FAULT,
	output logic            REGEN_INHIBIT_RX,
	output logic            REGEN_HOT_RX
);
	int n_frames = 0;
	initial begin
		FAULT = '0;
		REGEN_INHIBIT_RX = 1'b0;
		REGEN_HOT_RX = 1'b0;
	end
	// Counts speed messages
	always @(posedge MCLK) if (TSC1_SEND === 1'b1) n_frames <= n_frames + 1;
	// One-cycle report, then an idle pattern unlike the last one
	task automatic report(input logic [19:0] s, input logic [4:0] f,
			input logic act);
		@(posedge MCLK);
		FAULT <= '{1'b1, act, f, s};
		@(posedge MCLK);
		FAULT <= '{1'b0, ~act, ~f, ~s};
		@(posedge MCLK);
	endtask
	task automatic regen(input logic inh, input logic hot);
		@(posedge MCLK);
		REGEN_INHIBIT_RX <= inh;
		REGEN_HOT_RX <= hot;
		repeat (3) @(posedge MCLK);
	endtask
endmodule // ecu_model
`default_nettype wire

// ---- sim/engine_shutdown_throttle_ctrl_tb_top.sv ----
/* Self-checking bench: AXI4-Lite tasks, pin presses, ECU model.
   Assumes a 10-cycle tick so one second is 10000 clocks. */
`timescale 1ns/1ps
`default_nettype none
module engine_shutdown_throttle_ctrl_tb_top;
	logic mclk = 0, reset_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [5:0] pin = 0;
	logic [15:0] arpm = 0, mx, mn;
	logic [19:0] s;
	logic [4:0] fm;
	int n_errors = 0, samples_checked = 0, n, f, n_pr = 0;
	logic pon = 0;
	wire logic awr, wr_, bv, arr, rv, stop, inh, pop, red, aud, ce, si, ri, ra;
	wire logic tsend, pal, pdl, pak, phold;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [19:0] pspn;
	wire logic [4:0] pfmi;
	wire logic [15:0] trpm;
	wire esd_pkg::fault_t flt;
	wire logic rinh, rhot;
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk)
		if (reset_n) n_pr <= n_pr + pal + 16 * pdl + 256 * pak;
	ecu_model i_ecu_model (.MCLK(mclk), .TSC1_SEND(tsend), .FAULT(flt),
		.REGEN_INHIBIT_RX(rinh), .REGEN_HOT_RX(rhot));
	engine_shutdown_throttle_ctrl #(.TICK_CYCLES(10))
		i_engine_shutdown_throttle_ctrl (
		.MCLK(mclk), .RESET_N(reset_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.IGNITION(pin[5]), .BTN_UP(pin[3]), .BTN_DOWN(pin[4]),
		.BTN_SELECT(pin[2]), .THR_RAISE(pin[0]), .THR_LOWER(pin[1]),
		.FAULT(flt), .REGEN_INHIBIT_RX(rinh), .REGEN_HOT_RX(rhot),
		.ANALOG_RPM(arpm), .PROMPT_ON(pon), .PROMPT_NEED_ACK(pon),
		.PROMPT_ALLOW(pal), .PROMPT_DELAY(pdl), .PROMPT_ACK(pak),
		.PROMPT_HOLD(phold),
		.ENGINE_STOP(stop), .START_INHIBIT(inh), .POPUP(pop),
		.POPUP_SPN(pspn), .POPUP_FMI(pfmi), .RED_STATE(red), .AUDIBLE(aud),
		.CHECK_ENGINE(ce), .STOP_ICON(si), .REGEN_INH_ICON(ri),
		.REGEN_ACT_ICON(ra), .TSC1_SEND(tsend), .TSC1_RPM(trpm));
	function automatic logic [15:0] clampf(input logic [15:0] v, lo, hi);
		return (v > hi) ? hi : ((v < lo) ? lo : v);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		logic ga, gw;
		ga = 0;
		gw = 0;
		@(posedge mclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		while (!(ga && gw)) begin
			@(posedge mclk);
			if (!ga && awr === 1'b1) begin
				ga = 1;
				awv <= 0;
			end
			if (!gw && wr_ === 1'b1) begin
				gw = 1;
				wv <= 0;
			end
		end
		do @(posedge mclk); while (bv !== 1'b1);
		bry <= 0;
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er);
		@(posedge mclk);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do @(posedge mclk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge mclk); while (rv !== 1'b1);
		rry <= 0;
		chk("rdata", e, rdata);
		chk("rresp", er, rresp);
	endtask
	task automatic press(input int b, input int cyc);
		@(posedge mclk);
		pin[b] <= 1;
		repeat (cyc) @(posedge mclk);
		pin[b] <= 0;
		repeat (20) @(posedge mclk);
	endtask
	task automatic key_cycle;
		@(posedge mclk);
		pin[5] <= 0;
		repeat (20) @(posedge mclk);
		pin[5] <= 1;
		repeat (20) @(posedge mclk);
	endtask
	initial begin
		#600_000;
		n_errors++;
		end_sim;
	end
	initial begin
		void'($urandom(47746));
		repeat (3) @(posedge mclk);
		reset_n <= 1;
		rd(esd_pkg::OFS_CFG, esd_pkg::CFG_RST, esd_pkg::RESP_OKAY);
		rd(esd_pkg::OFS_LIM, esd_pkg::LIM_RST, esd_pkg::RESP_OKAY);
		rd(8'h20, 32'h0, esd_pkg::RESP_SLVERR);
		wr(esd_pkg::OFS_STS, 32'h1, esd_pkg::RESP_SLVERR);
		pin[5] <= 1;
		n = $urandom_range(4, 1);
		repeat (n) press(0, 5);
		rd(esd_pkg::OFS_SPEED, 800 + 10 * n, esd_pkg::RESP_OKAY);
		repeat (n + 1) press(1, 5);
		rd(esd_pkg::OFS_SPEED, 32'd800, esd_pkg::RESP_OKAY);
		press(0, 21100);
		rd(esd_pkg::OFS_SPEED, 800 + 10 + 5, esd_pkg::RESP_OKAY);
		mx = 16'(1000 + $urandom_range(2000));
		mn = 16'(600 + $urandom_range(300));
		arpm = 16'($urandom_range(4000));
		wr(esd_pkg::OFS_CFG, 32'h5, esd_pkg::RESP_OKAY);
		wr(esd_pkg::OFS_LIM, {mx, mn}, esd_pkg::RESP_OKAY);
		press(0, 5);
		rd(esd_pkg::OFS_SPEED, 32'd825, esd_pkg::RESP_OKAY);
		press(2, 10100);
		press(0, 5);
		rd(esd_pkg::OFS_SPEED, mx, esd_pkg::RESP_OKAY);
		do @(posedge mclk); while (tsend !== 1'b1);
		chk("tsc1_rpm", clampf(arpm, mn, mx), trpm);
		press(1, 5);
		rd(esd_pkg::OFS_SPEED, mn, esd_pkg::RESP_OKAY);
		wr(esd_pkg::OFS_CFG, 32'h2, esd_pkg::RESP_OKAY);
		press(2, 10100);
		press(1, 5);
		f = i_ecu_model.n_frames;
		repeat (300) @(posedge mclk);
		chk("frames", f, i_ecu_model.n_frames);
		pon <= 1;
		press(4, 5);
		press(3, 5);
		chk("prompt_hold", 1, phold);
		press(2, 30);
		chk("prompt_hold", 0, phold);
		chk("prompt_keys", 273, n_pr);
		pon <= 0;
		s = 20'($urandom_range(599999));
		fm = 5'($urandom_range(31));
		wr(esd_pkg::OFS_ALM, {7'h02, fm, s}, esd_pkg::RESP_OKAY);
		i_ecu_model.report(s, fm + 5'h1, 1'b1);
		chk("popup", 0, pop);
		i_ecu_model.report(s, fm, 1'b1);
		chk("popup", 1, pop);
		chk("stop", 1, stop);
		chk("spn", s, pspn);
		chk("fmi", fm, pfmi);
		chk("audible", 1, aud);
		press(2, 30);
		chk("popup", 0, pop);
		chk("audible", 0, aud);
		chk("red", 1, red);
		chk("check", 2'b11, {ce, si});
		chk("inhibit", 1, inh);
		wr(esd_pkg::OFS_CMD, 32'h1, esd_pkg::RESP_OKAY);
		rd(esd_pkg::OFS_OVRCNT, 32'h0, esd_pkg::RESP_OKAY);
		key_cycle();
		chk("popup", 1, pop);
		wr(esd_pkg::OFS_CMD, 32'h1, esd_pkg::RESP_OKAY);
		chk("inhibit", 0, inh);
		key_cycle();
		chk("inhibit", 1, inh);
		rd(esd_pkg::OFS_OVRCNT, 32'h1, esd_pkg::RESP_OKAY);
		i_ecu_model.report(s, fm, 1'b0);
		key_cycle();
		chk("popup", 1, pop);
		chk("inhibit", 1, inh);
		i_ecu_model.regen(1'b1, 1'b0);
		chk("regen", 2'b10, {ri, ra});
		i_ecu_model.regen(1'b0, 1'b1);
		chk("regen", 2'b01, {ri, ra});
		end_sim;
	end
endmodule // engine_shutdown_throttle_ctrl_tb_top
`default_nettype wire
